// ### mie_exec_unit.sv
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_exec_unit
    import mie_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        instr_valid,
    input  mie_instr_t       instr,
    input  wire logic        wdog_tick,
    input  wire logic        wake_pin,
    output logic             ready_reg,
    output logic      [7:0]  working_register,
    output mie_flags_t       flags_reg,
    output logic      [11:0] pc_reg,
    output logic      [11:0] stack_top,
    output logic      [7:0]  watchdog_counter,
    output logic             sys_clock_enable_reg,
    output logic             prescaler_clear_reg,
    output logic             halted_reg
);
    // ****************************************
    // adder shared by add, plus one and minus one
    // ****************************************
    function automatic mie_sum_t add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        mie_sum_t   r;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res = full[7:0];
        r.c   = full[8];
        r.hc  = low[4];
        r.ov  = (a[7] == b[7]) && (full[7] != a[7]);
        return r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    mie_state_t st_reg;
    mie_state_t st_next;
    mie_instr_t ins_reg;
    mie_flags_t flg_next;
    logic [1:0] div_reg;
    logic [1:0] left_reg;
    logic [1:0] left_next;
    logic [7:0] work_reg;
    logic [7:0] work_next;
    logic [11:0] pc_next;
    logic [7:0] wdog_reg;
    logic [7:0] wdog_next;
    logic       pre1_reg;
    logic       pre2_reg;
    logic       wake_s1_reg;
    logic       wake_s2_reg;
    logic [7:0] ram_q;
    logic [7:0] res;
    logic       to_mem;
    logic       to_work;
    logic       upd_zero;
    logic       upd_sum;

    assign working_register = work_reg;
    assign watchdog_counter = wdog_reg;

    // ****************************************
    // instruction cycle divider
    // ****************************************
    wire tick = (div_reg == `MIE_DIV_LAST);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    // wake pin is asynchronous
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= wake_pin;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    wire        accept    = (st_reg == ST_IDLE) && tick && instr_valid;
    wire        exec      = (st_reg == ST_EXEC);
    mie_op_t    op;
    assign op = ins_reg.op;
    wire        imm_src   = (op == OP_ADD_IMM) || (op == OP_AND_IMM);
    wire [7:0]  opnd      = imm_src ? ins_reg.imm : ram_q;
    wire        use_carry = (op == OP_ADD_CARRY_W) || (op == OP_ADD_CARRY_MEM);
    wire        is_branch = (op == OP_CALL) || (op == OP_GOTO);
    mie_sum_t   sum_r;
    mie_sum_t   inc_r;
    mie_sum_t   dec_r;
    assign sum_r = add8(work_reg, opnd, use_carry & flags_reg.carry);
    assign inc_r = add8(ram_q, `MIE_ONE_BYTE, 1'b0);
    assign dec_r = add8(ram_q, `MIE_FULL_BYTE, 1'b0);
    wire [7:0]  and_r     = work_reg & opnd;
    wire [7:0]  bitclr_r  = ram_q & ~(`MIE_ONE_BYTE << ins_reg.bit_sel);

    // ****************************************
    // decimal adjust
    // ****************************************
    wire        lo_fix  = ({1'b0, work_reg[3:0]} > `MIE_BCD_LIMIT)
                          || flags_reg.half_carry_flag;
    wire        nibble_carry_internal = lo_fix & ~flags_reg.half_carry_flag;
    wire [3:0]  lo_r    = lo_fix ? work_reg[3:0] + `MIE_BCD_FIX : work_reg[3:0];
    wire [4:0]  hi_sum  = {1'b0, work_reg[7:4]} + {4'h0, nibble_carry_internal};
    wire        hi_fix  = (hi_sum > `MIE_BCD_LIMIT) || flags_reg.carry;
    wire [3:0]  hi_r    = hi_fix ? hi_sum[3:0] + `MIE_BCD_FIX : hi_sum[3:0];

    // ****************************************
    // result select
    // ****************************************
    always_comb begin
        res      = sum_r.res;
        to_mem   = 1'b0;
        to_work  = 1'b0;
        upd_zero = 1'b0;
        upd_sum  = 1'b0;
        case (op)
            OP_ADD_CARRY_W, OP_ADD_W, OP_ADD_IMM: begin
                to_work = 1'b1;
                upd_sum = 1'b1;
            end
            OP_ADD_CARRY_MEM, OP_SUM_MEM: begin
                to_mem  = 1'b1;
                upd_sum = 1'b1;
            end
            OP_AND_W, OP_AND_IMM, OP_AND_MEM: begin
                res      = and_r;
                to_mem   = (op == OP_AND_MEM);
                to_work  = (op != OP_AND_MEM);
                upd_zero = 1'b1;
            end
            OP_ZERO: begin
                res    = `MIE_ZERO_BYTE;
                to_mem = 1'b1;
            end
            OP_ZERO_BIT: begin
                res    = bitclr_r;
                to_mem = 1'b1;
            end
            OP_INVERT, OP_INVERT_W: begin
                res      = ~ram_q;
                to_mem   = (op == OP_INVERT);
                to_work  = (op == OP_INVERT_W);
                upd_zero = 1'b1;
            end
            OP_MINUS_ONE, OP_MINUS_ONE_W: begin
                res      = dec_r.res;
                to_mem   = (op == OP_MINUS_ONE);
                to_work  = (op == OP_MINUS_ONE_W);
                upd_zero = 1'b1;
            end
            OP_PLUS_ONE, OP_PLUS_ONE_W: begin
                res      = inc_r.res;
                to_mem   = (op == OP_PLUS_ONE);
                to_work  = (op == OP_PLUS_ONE_W);
                upd_zero = 1'b1;
            end
            OP_BCD_FIXUP: begin
                res    = {hi_r, lo_r};
                to_mem = 1'b1;
            end
            default: begin
                res = sum_r.res;
            end
        endcase
    end

    wire        mem_we    = exec && to_mem;
    wire        pcl_hit   = mem_we && (ins_reg.addr == `MIE_PCL_ADDR);
    wire [1:0]  cycles    = (is_branch || pcl_hit) ? `MIE_CYC_TWO : `MIE_CYC_ONE;
    wire [11:0] pc_inc    = pc_reg + `MIE_PC_STEP;
    wire        push      = exec && (op == OP_CALL);

    // ****************************************
    // watchdog
    // ****************************************
    wire pair_done = exec && (((op == OP_WDOG_PRE1) && pre2_reg)
                           || ((op == OP_WDOG_PRE2) && pre1_reg));
    wire wdog_clr  = (exec && (op == OP_WDOG_CLEAR)) || pair_done;
    wire halt_go   = exec && (op == OP_HALT);
    wire overflow  = wdog_tick && (wdog_reg == `MIE_FULL_BYTE);

    assign wdog_next = (wdog_clr || halt_go) ? `MIE_ZERO_BYTE :
                       wdog_tick ? wdog_reg + `MIE_ONE_BYTE : wdog_reg;
    wire   pre1_next = pair_done ? 1'b0 :
                       (exec && (op == OP_WDOG_PRE1)) ? 1'b1 : pre1_reg;
    wire   pre2_next = pair_done ? 1'b0 :
                       (exec && (op == OP_WDOG_PRE2)) ? 1'b1 : pre2_reg;

    // ****************************************
    // flags, working register, program counter
    // ****************************************
    always_comb begin
        flg_next = flags_reg;
        // expiry set by overflow wins over any clear
        flg_next.watchdog_expiry_flag = overflow
            || (flags_reg.watchdog_expiry_flag && !(wdog_clr || halt_go));
        flg_next.power_down_flag = halt_go
            || (flags_reg.power_down_flag && !wdog_clr);
        if (exec && upd_sum) begin
            flg_next.carry             = sum_r.c;
            flg_next.half_carry_flag   = sum_r.hc;
            flg_next.signed_range_flag = sum_r.ov;
        end
        if (exec && (upd_sum || upd_zero)) begin
            flg_next.zero = (res == `MIE_ZERO_BYTE);
        end
        if (exec && (op == OP_BCD_FIXUP)) begin
            flg_next.carry = hi_fix || flags_reg.carry;
        end
    end

    assign work_next = (exec && to_work) ? res : work_reg;
    assign pc_next   = !exec ? pc_reg :
                       is_branch ? ins_reg.target :
                       pcl_hit ? {pc_reg[11:8], res} : pc_inc;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        st_next   = st_reg;
        left_next = left_reg;
        case (st_reg)
            ST_IDLE: begin
                if (accept) begin
                    st_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                st_next   = (op == OP_HALT) ? ST_HALT : ST_WAIT;
                left_next = cycles;
            end
            ST_WAIT: begin
                if (tick) begin
                    left_next = left_reg - 2'h1;
                    if (left_reg == `MIE_CYC_ONE) begin
                        st_next = ST_IDLE;
                    end
                end
            end
            ST_HALT: begin
                if (wake_s2_reg || overflow) begin
                    st_next   = ST_WAIT;
                    left_next = `MIE_CYC_ONE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_reg               <= ST_IDLE;
            ins_reg              <= '0;
            left_reg             <= 2'h0;
            work_reg             <= `MIE_ZERO_BYTE;
            flags_reg            <= '0;
            pc_reg               <= `MIE_PC_RESET;
            wdog_reg             <= `MIE_ZERO_BYTE;
            pre1_reg             <= 1'b0;
            pre2_reg             <= 1'b0;
            ready_reg            <= 1'b0;
            sys_clock_enable_reg <= 1'b1;
            prescaler_clear_reg  <= 1'b0;
            halted_reg           <= 1'b0;
        end else begin
            st_reg               <= st_next;
            ins_reg              <= accept ? instr : ins_reg;
            left_reg             <= left_next;
            work_reg             <= work_next;
            flags_reg            <= flg_next;
            pc_reg               <= pc_next;
            wdog_reg             <= wdog_next;
            pre1_reg             <= pre1_next;
            pre2_reg             <= pre2_next;
            ready_reg            <= (st_next == ST_IDLE);
            sys_clock_enable_reg <= (st_next != ST_HALT);
            prescaler_clear_reg  <= halt_go;
            halted_reg           <= (st_next == ST_HALT);
        end
    end

    mie_data_ram u_ram (
        .clock     (clock),
        .we        (mem_we),
        .waddr     (ins_reg.addr),
        .wdata     (res),
        .raddr     (instr.addr),
        .rdata_reg (ram_q)
    );

    mie_stack u_stack (
        .clock     (clock),
        .reset_n   (reset_n),
        .push      (push),
        .push_data (pc_inc),
        .top_reg   (stack_top)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    clear_byte_a: assert property (exec && op == OP_ZERO |-> mem_we && res == 8'h00)
        else $error("byte clear did not write zero");
    and_zero_a: assert property (exec && op == OP_AND_IMM |=>
        work_reg == ($past(work_reg) & $past(ins_reg.imm)) && flags_reg.zero == (work_reg == 8'h00)
        && $stable(flags_reg.carry))
        else $error("and result or zero flag wrong");
    call_push_a: assert property (exec && op == OP_CALL |=>
        pc_reg == $past(ins_reg.target) && stack_top == $past(pc_reg) + 12'h001)
        else $error("call did not push and load");
    goto_pc_a: assert property (exec && op == OP_GOTO |=> pc_reg == $past(ins_reg.target))
        else $error("goto did not load target");
    wdog_clear_a: assert property (exec && op == OP_WDOG_CLEAR && !wdog_tick |=>
        wdog_reg == 8'h00 && !flags_reg.watchdog_expiry_flag && !flags_reg.power_down_flag)
        else $error("watchdog clear incomplete");
    pair_clear_a: assert property (exec && op == OP_WDOG_PRE2 && pre1_reg && !wdog_tick |=>
        wdog_reg == 8'h00 && !pre1_reg && !pre2_reg && !flags_reg.power_down_flag)
        else $error("paired preclear did not clear");
    single_pre_a: assert property (exec && op == OP_WDOG_PRE1 && !pre2_reg && !wdog_tick |=>
        pre1_reg && $stable(flags_reg.power_down_flag) && wdog_reg == $past(wdog_reg))
        else $error("single preclear changed state");
    halt_entry_a: assert property (exec && op == OP_HALT && !wdog_tick |=>
        flags_reg.power_down_flag && !flags_reg.watchdog_expiry_flag && !sys_clock_enable_reg
        && prescaler_clear_reg ##1 !prescaler_clear_reg)
        else $error("halt entry wrong");
    pcl_cycle_a: assert property (exec && pcl_hit |=> !ready_reg [*7] ##1 ready_reg)
        else $error("low byte write did not stretch cycle");
    plain_cycle_a: assert property (exec && !pcl_hit && !is_branch && op != OP_HALT |=>
        !ready_reg [*3] ##1 ready_reg)
        else $error("normal instruction cycle length wrong");
endmodule // mie_exec_unit

// ### mie_consts.svh
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
// ****************************************
// timing
// ****************************************
`define MIE_CLK_PERIOD_NS 25
`define MIE_CLKS_PER_CYCLE 4
`define MIE_DIV_LAST 2'h3
`define MIE_CYC_ONE 2'h1
`define MIE_CYC_TWO 2'h2
// ****************************************
// memory map and sizes
// ****************************************
`define MIE_RAM_DEPTH 88
`define MIE_STACK_DEPTH 4
`define MIE_PCL_ADDR 7'h02
// ****************************************
// values
// ****************************************
`define MIE_BCD_LIMIT 5'h09
`define MIE_BCD_FIX 4'h6
`define MIE_ZERO_BYTE 8'h00
`define MIE_FULL_BYTE 8'hFF
`define MIE_ONE_BYTE 8'h01
`define MIE_PC_RESET 12'h000
`define MIE_PC_STEP 12'h001
`endif

// ### mie_pkg.sv
package mie_pkg;
    // ****************************************
    // instruction set subset
    // ****************************************
    typedef enum logic [4:0] {
        OP_NOP           = 5'h00,
        OP_ADD_CARRY_W   = 5'h01,
        OP_ADD_CARRY_MEM = 5'h02,
        OP_ADD_W         = 5'h03,
        OP_ADD_IMM       = 5'h04,
        OP_SUM_MEM       = 5'h05,
        OP_AND_W         = 5'h06,
        OP_AND_IMM       = 5'h07,
        OP_AND_MEM       = 5'h08,
        OP_CALL          = 5'h09,
        OP_ZERO          = 5'h0A,
        OP_ZERO_BIT      = 5'h0B,
        OP_WDOG_CLEAR    = 5'h0C,
        OP_WDOG_PRE1     = 5'h0D,
        OP_WDOG_PRE2     = 5'h0E,
        OP_INVERT        = 5'h0F,
        OP_INVERT_W      = 5'h10,
        OP_BCD_FIXUP     = 5'h11,
        OP_MINUS_ONE     = 5'h12,
        OP_MINUS_ONE_W   = 5'h13,
        OP_HALT          = 5'h14,
        OP_PLUS_ONE      = 5'h15,
        OP_PLUS_ONE_W    = 5'h16,
        OP_GOTO          = 5'h17
    } mie_op_t;

    typedef struct packed {
        mie_op_t     op;
        logic [6:0]  addr;
        logic [7:0]  imm;
        logic [2:0]  bit_sel;
        logic [11:0] target;
    } mie_instr_t;

    typedef struct packed {
        logic watchdog_expiry_flag;
        logic power_down_flag;
        logic signed_range_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } mie_flags_t;

    typedef struct packed {
        logic [7:0] res;
        logic       c;
        logic       hc;
        logic       ov;
    } mie_sum_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EXEC = 4'h2,
        ST_WAIT = 4'h4,
        ST_HALT = 4'h8
    } mie_state_t;
endpackage

// ### mie_data_ram.sv
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_data_ram (
    input  wire logic       clock,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [6:0] raddr,
    output logic      [7:0] rdata_reg
);
    logic [7:0] mem_array [0:`MIE_RAM_DEPTH-1];
    wire        wr_ok = we && (waddr < 7'(`MIE_RAM_DEPTH));
    wire        rd_ok = raddr < 7'(`MIE_RAM_DEPTH);

    // contents are retained through reset and halt
    always_ff @(posedge clock) begin
        if (wr_ok) begin
            mem_array[waddr] <= wdata;
        end
        rdata_reg <= rd_ok ? mem_array[raddr] : `MIE_ZERO_BYTE;
    end
endmodule // mie_data_ram

// ### mie_stack.sv
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_stack (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        push,
    input  wire logic [11:0] push_data,
    output logic      [11:0] top_reg
);
    logic [11:0] level [0:`MIE_STACK_DEPTH-1];
    logic [1:0]  ptr_reg;

    // oldest level is overwritten once all levels are used
    always_ff @(posedge clock) begin
        if (push) begin
            level[ptr_reg] <= push_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptr_reg <= 2'h0;
            top_reg <= `MIE_PC_RESET;
        end else if (push) begin
            ptr_reg <= ptr_reg + 2'h1;
            top_reg <= push_data;
        end
    end
endmodule // mie_stack

// ### mie_env_model.sv
`timescale 1ns/1ps
// ****************************************
// watchdog tick source and wake pin
// ****************************************
module mie_env_model (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic tick_en,
    input  wire logic wake_req,
    output logic      wdog_tick,
    output logic      wake_pin
);
    logic [1:0] gap_reg;
    // one tick pulse every fourth clock while enabled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap_reg   <= 2'h0;
            wdog_tick <= 1'b0;
        end else begin
            gap_reg   <= gap_reg + 2'h1;
            wdog_tick <= tick_en && (gap_reg == 2'h3);
        end
    end
    // wake pin is pulled low when not requested
    assign wake_pin = wake_req;
endmodule // mie_env_model

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t mismatch %0h %0h", $time, got, exp); end end
module tb_top;
    import mie_pkg::*;
    // ****************************************
    // signals and reference state
    // ****************************************
    logic        clock       = 1'b0;
    logic        reset_n     = 1'b0;
    logic        instr_valid = 1'b0;
    mie_instr_t  instr       = '0;
    logic        tick_en     = 1'b0;
    logic        wake_req    = 1'b0;
    logic        wdog_tick, wake_pin, ready_reg, sys_clock_enable_reg;
    logic        prescaler_clear_reg, halted_reg;
    logic [7:0]  working_register, watchdog_counter;
    logic [11:0] pc_reg, stack_top;
    mie_flags_t  flags_reg;
    int          mem [88];
    int          w, pc, stk, wd, bad_count, samples_checked, a, k;
    bit          to_f, pdf_f, ov_f, z_f, hc_f, c_f, pre1, pre2;
    mie_op_t     ops [17] = '{OP_ADD_CARRY_W, OP_ADD_CARRY_MEM, OP_ADD_W, OP_ADD_IMM,
        OP_SUM_MEM, OP_AND_W, OP_AND_IMM, OP_AND_MEM, OP_ZERO, OP_ZERO_BIT, OP_INVERT,
        OP_INVERT_W, OP_BCD_FIXUP, OP_MINUS_ONE, OP_MINUS_ONE_W, OP_PLUS_ONE, OP_PLUS_ONE_W};
    mie_op_t     wops [6] = '{OP_HALT, OP_WDOG_PRE1, OP_WDOG_PRE2, OP_HALT, OP_WDOG_PRE2,
        OP_WDOG_CLEAR};

    always #12.5 clock = ~clock;
    always @(posedge clock) if (wdog_tick === 1'b1) wd = (wd + 1) & 255;

    mie_exec_unit dut_u (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .wdog_tick(wdog_tick), .wake_pin(wake_pin), .ready_reg(ready_reg),
        .working_register(working_register), .flags_reg(flags_reg), .pc_reg(pc_reg),
        .stack_top(stack_top), .watchdog_counter(watchdog_counter),
        .sys_clock_enable_reg(sys_clock_enable_reg),
        .prescaler_clear_reg(prescaler_clear_reg), .halted_reg(halted_reg));
    mie_env_model env_u (.clock(clock), .reset_n(reset_n), .tick_en(tick_en),
        .wake_req(wake_req), .wdog_tick(wdog_tick), .wake_pin(wake_pin));

    // ****************************************
    // reference model
    // ****************************************
    function automatic mie_instr_t mk(mie_op_t o, int ad = 0, int x = 0, int b = 0, int t = 0);
        mk = '{o, 7'(ad), 8'(x), 3'(b), 12'(t)};
    endfunction

    function automatic void exec(mie_instr_t i);
        int m, r, b, ci, lo, hi, ac1;
        bit wm;
        m = (i.addr < 88) ? mem[i.addr] : 0;
        r = 0;
        wm = 0;
        pc = (pc + 1) & 12'hFFF;
        case (i.op)
            OP_ADD_CARRY_W, OP_ADD_CARRY_MEM, OP_ADD_W, OP_ADD_IMM, OP_SUM_MEM: begin
                b = (i.op == OP_ADD_IMM) ? i.imm : m;
                ci = (i.op inside {OP_ADD_CARRY_W, OP_ADD_CARRY_MEM}) ? c_f : 0;
                r = w + b + ci;
                c_f = r >> 8;
                hc_f = ((w & 15) + (b & 15) + ci) >> 4;
                ov_f = ((~(w ^ b)) & (w ^ r) & 128) != 0;
                r = r & 255;
                z_f = (r == 0);
                if (i.op inside {OP_ADD_CARRY_MEM, OP_SUM_MEM}) wm = 1; else w = r;
            end
            OP_AND_W, OP_AND_IMM, OP_AND_MEM: begin
                r = w & ((i.op == OP_AND_IMM) ? i.imm : m);
                z_f = (r == 0);
                if (i.op == OP_AND_MEM) wm = 1; else w = r;
            end
            OP_INVERT, OP_INVERT_W, OP_MINUS_ONE, OP_MINUS_ONE_W, OP_PLUS_ONE, OP_PLUS_ONE_W: begin
                r = (i.op inside {OP_INVERT, OP_INVERT_W}) ? ~m :
                    (i.op inside {OP_PLUS_ONE, OP_PLUS_ONE_W}) ? m + 1 : m - 1;
                r = r & 255;
                z_f = (r == 0);
                if (i.op inside {OP_INVERT, OP_MINUS_ONE, OP_PLUS_ONE}) wm = 1; else w = r;
            end
            OP_BCD_FIXUP: begin
                lo = w & 15;
                ac1 = 0;
                if (lo > 9 || hc_f) begin lo = lo + 6; ac1 = !hc_f; end
                hi = (w >> 4) + ac1;
                if (hi > 9 || c_f) begin hi = hi + 6; c_f = 1; end
                r = ((hi & 15) << 4) | (lo & 15);
                wm = 1;
            end
            OP_CALL: begin stk = pc; pc = i.target; end
            OP_GOTO: pc = i.target;
            OP_ZERO: wm = 1;
            OP_ZERO_BIT: begin r = m & ~(1 << i.bit_sel) & 255; wm = 1; end
            OP_WDOG_CLEAR: begin wd = 0; to_f = 0; pdf_f = 0; end
            OP_WDOG_PRE1, OP_WDOG_PRE2: begin
                if (i.op == OP_WDOG_PRE1) pre1 = 1; else pre2 = 1;
                if (pre1 && pre2) begin wd = 0; to_f = 0; pdf_f = 0; pre1 = 0; pre2 = 0; end
            end
            OP_HALT: begin wd = 0; to_f = 0; pdf_f = 1; end
            default: ;
        endcase
        if (wm && i.addr < 88) begin
            mem[i.addr] = r;
            if (i.addr == 2) pc = (pc & 12'hF00) | r;
        end
    endfunction

    // ****************************************
    // tasks
    // ****************************************
    task automatic test_done();
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("[FAIL] %0t timeout", $time);
        test_done();
    endtask

    task automatic run(input mie_instr_t i, input int cyc = 4);
        int n;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr       <= i;
        n = 0;
        do begin @(posedge clock); n++; end while (ready_reg !== 1'b0 && n < 12);
        if (n >= 12) hang();
        instr_valid <= 1'b0;
        if (i.op == OP_HALT) begin
            @(posedge clock);
            `CHK(halted_reg, 1'b1)
            `CHK(sys_clock_enable_reg, 1'b0)
            `CHK(prescaler_clear_reg, 1'b1)
            wake_req <= 1'b1;
        end
        n = 0;
        do begin @(posedge clock); n++; end while (ready_reg !== 1'b1 && n < 40);
        if (n >= 40) hang();
        wake_req <= 1'b0;
        if (cyc != 0) `CHK(n, cyc)
        exec(i);
        `CHK(working_register, 8'(w))
        `CHK(flags_reg, mie_flags_t'({to_f, pdf_f, ov_f, z_f, hc_f, c_f}))
        `CHK(pc_reg, 12'(pc))
        `CHK(stack_top, 12'(stk))
        `CHK(watchdog_counter, 8'(wd))
    endtask

    task automatic ld(input int v);
        run(mk(OP_AND_IMM, 0, 0));
        run(mk(OP_ADD_IMM, 0, v));
    endtask

    task automatic tick();
        tick_en <= 1'b1;
        repeat (24) @(posedge clock);
        tick_en <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h526845EE));
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        run(mk(OP_CALL, 0, 0, 0, 12'h0A5), 8);
        run(mk(OP_GOTO, 0, 0, 0, 12'h040), 8);
        run(mk(OP_ZERO, 2), 8);
        for (a = 16; a < 24; a++) begin
            run(mk(OP_ZERO, a));
            ld($urandom_range(255));
            run(mk(OP_SUM_MEM, a));
        end
        for (k = 0; k < 300; k++)
            run(mk(ops[$urandom_range(16)], 16 + $urandom_range(7), $urandom_range(255),
                $urandom_range(7)));
        for (a = 16; a < 24; a++) begin
            ld(255);
            run(mk(OP_AND_W, a));
        end
        for (k = 0; k < 6; k++) begin
            tick();
            run(mk(OP_NOP));
            run(mk(wops[k]), (wops[k] == OP_HALT) ? 0 : 4);
        end
        test_done();
    end
endmodule // tb_top
